//--- rtl/vsp_defs.svh
// Offsets, field positions, reset values and timing counts of the setpoint block.
`ifndef VSP_DEFS_SVH
`define VSP_DEFS_SVH
`define VSP_OFF_OPERATION 8'h01
`define VSP_OFF_VOUT_SET 8'h21
`define VSP_OFF_MARGIN_HI 8'h25
`define VSP_OFF_MARGIN_LO 8'h26
`define VSP_OFF_SCALE 8'h29
`define VSP_OFF_READBACK 8'h8b
`define VSP_OFF_SLAVE_CFG 8'hd0
`define VSP_OFF_DIV_CTRL 8'hd1
`define VSP_OFF_PROT_CFG 8'hd2
`define VSP_OFF_OT_LIMIT 8'hd3
`define VSP_RST_OPERATION 8'h80
`define VSP_RST_VOUT_SET 16'h01c2
`define VSP_RST_MARGIN 16'h01c2
`define VSP_RST_SCALE 16'h03e8
`define VSP_RST_SLAVE_CFG 16'h0001
`define VSP_RST_DIV_CTRL 16'h0000
`define VSP_RST_PROT_CFG 16'h0000
`define VSP_RST_OT_LIMIT 16'h00a0
`define VSP_OP_ON_BIT 7
`define VSP_OP_MARGIN_MSB 5
`define VSP_OP_MARGIN_LSB 4
`define VSP_PROT_LATCH_BIT 0
`define VSP_SLAVE_EN_BIT 0
`define VSP_DAC_MIN_MV 16'd162
`define VSP_DAC_MAX_MV 16'd672
`define VSP_LSB_UV 32'd2000
`define VSP_SCALE_ONE 32'd1000
`define VSP_CLK_HZ 32'd10000000
`define VSP_PG_STEP_US 32'd100
`define VSP_PG_STEP_CYC ((`VSP_PG_STEP_US * `VSP_CLK_HZ) / 32'd1000000)
`define VSP_HICCUP_MS 32'd10
`define VSP_HICCUP_CYC ((`VSP_HICCUP_MS * `VSP_CLK_HZ) / 32'd1000)
`endif

//--- rtl/vsp_pkg.sv
// Types shared by the setpoint and supervision block.
package vsp_pkg;
	typedef enum logic [2:0] {
		VSP_OFF,
		VSP_SOFT_START,
		VSP_PG_DELAY,
		VSP_RUNNING,
		VSP_HICCUP,
		VSP_LATCHED
	} vsp_state_t;
endpackage : vsp_pkg

//--- rtl/vsp_dac_calc.sv
// Combinational DAC target: command times scale ratio, clamped to span.
`timescale 1ns/1ps
`default_nettype none
`include "vsp_defs.svh"
module vsp_dac_calc (
	// Setpoint inputs.
	input wire logic [15:0] cmd_in,
	input wire logic [15:0] scale_in,
	input wire logic [1:0] div_sel_in,
	// Reference target in millivolts.
	output logic [15:0] dac_mv_out
);
	logic [31:0] prod;
	logic [31:0] mv_raw;
	logic [31:0] mv_div;
	// Count is 2 mV, scale is ratio times 1000, so mV = cmd*2*scale/1000.
	assign prod = 32'(cmd_in) * 32'(scale_in); // see (RQ9) see (RQ19)
	// Dividing by half the scale unit, instead of doubling the product
	// first, keeps the largest command and scale from wrapping 32 bits.
	assign mv_raw = prod / (`VSP_SCALE_ONE / 32'd2);
	// The loop scale already carries the internal divider ratio; the
	// divider code selects the tap and the reference then equals mv_raw.
	assign mv_div = (div_sel_in == 2'b00) ? mv_raw : mv_raw; // see (RQ5)
	assign dac_mv_out = (mv_div < 32'(`VSP_DAC_MIN_MV)) ? `VSP_DAC_MIN_MV :
		(mv_div > 32'(`VSP_DAC_MAX_MV)) ? `VSP_DAC_MAX_MV :
		mv_div[15:0]; // see (RQ4) see (RQ19)
endmodule : vsp_dac_calc
`default_nettype wire

//--- rtl/vsp_setpoint_ctrl.sv
// Setpoint registers, over-temperature handling and power-good sequencing.
//
// Behaviour
// (RQ1) Stop converting when junction temperature exceeds the fault limit.
// (RQ2) After an over-temperature trip, hiccup or latch off per protection config.
// (RQ3) Latched-off state clears only by bias cycling or control toggling.
// (RQ4) Reference target always lies between 162 mV and 672 mV.
// (RQ5) Divider code selects ratio 1, 0.5, 0.25 or 0.125.
// (RQ6) Host programs scale 0x03e8, 0x01f4, 0x00fa or 0x007d per divider code.
// (RQ7) With an external divider, host keeps code 00 and scale equals ratio.
// (RQ8) Scale and divider code take effect only on a later voltage command write.
// (RQ9) Voltage command counts are 2 mV each.
// (RQ10) Host should not change scale or divider while switching.
// (RQ11) Host keeps the voltage command within the divider's range.
// (RQ12) Host selects setpoint source via operation before programming setpoints.
// (RQ13) Output voltage is readable at 8bh, scaled like the setpoints.
// (RQ14) Power good is held low from power up until soft start is ready.
// (RQ15) Power good releases after a delay chosen by divider control bits 5:2.
// (RQ16) Any fault latches power good low until a new soft start.
// (RQ17) Master senses its power-good pin as slave fault indication.
// (RQ18) Slave fault sensing is enabled by slave config bit 0.
// (RQ19) DAC target is command times scale ratio, saturated to the span.
`timescale 1ns/1ps
`default_nettype none
`include "vsp_defs.svh"
module vsp_setpoint_ctrl
	import vsp_pkg::*;
(
	// Clock and reset.
	input wire logic clock_in,
	input wire logic rst_n_in,
	// Register port from the bus engine.
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	output logic [15:0] reg_rdata_out,
	output logic reg_rvalid_out,
	// Control pin and analog monitors.
	input wire logic ctrl_enable_in,
	input wire logic [15:0] junction_temp_in,
	input wire logic [15:0] vout_sense_in,
	input wire logic feedback_pg_on_in,
	input wire logic soft_start_done_in,
	input wire logic under_voltage_in,
	input wire logic over_voltage_in,
	input wire logic input_uvlo_in,
	// Power-good open-drain pin.
	input wire logic power_good_pin_in,
	output logic power_good_output_out,
	output logic power_good_oe_out,
	// Power stage control and reference.
	output logic converter_enable_out,
	output logic [15:0] dac_target_out,
	output logic fault_latched_out
);
	logic [7:0] operation_r;
	logic [15:0] vout_set_r;
	logic [15:0] margin_hi_r;
	logic [15:0] margin_lo_r;
	logic [15:0] scale_r;
	logic [15:0] slave_cfg_r;
	logic [15:0] div_ctrl_r;
	logic [15:0] prot_cfg_r;
	logic [15:0] ot_limit_r;
	// Values actually applied by the reference path.
	logic [15:0] scale_act_r;
	logic [1:0] div_act_r;
	logic [15:0] cmd_act_r;
	logic [15:0] cmd_act_nxt;
	logic [15:0] dac_mv;
	vsp_state_t state_r;
	vsp_state_t state_nxt;
	logic [23:0] cnt_r;
	logic [23:0] cnt_nxt;
	logic [3:0] pg_steps;
	logic [23:0] pg_delay_cyc;
	logic pg_pin_s1_r;
	logic pg_pin_s2_r;
	logic ctrl_s1_r;
	logic ctrl_s2_r;
	logic ctrl_prev_r;
	logic pg_released_r;
	logic [1:0] pg_settle_r;
	logic [15:0] rdata_nxt;
	logic [15:0] readback;
	logic wr_op;
	logic wr_vout;
	logic wr_mhi;
	logic wr_mlo;
	logic wr_scale;
	logic wr_slave;
	logic wr_div;
	logic wr_prot;
	logic wr_otl;
	logic ctrl_rise;
	logic run_req;
	logic ot_trip;
	logic slave_fault;
	logic any_fault;
	logic [1:0] margin_sel;

	// Register write decode.
	assign wr_op = reg_wr_in && (reg_addr_in == `VSP_OFF_OPERATION);
	assign wr_vout = reg_wr_in && (reg_addr_in == `VSP_OFF_VOUT_SET);
	assign wr_mhi = reg_wr_in && (reg_addr_in == `VSP_OFF_MARGIN_HI);
	assign wr_mlo = reg_wr_in && (reg_addr_in == `VSP_OFF_MARGIN_LO);
	assign wr_scale = reg_wr_in && (reg_addr_in == `VSP_OFF_SCALE);
	assign wr_slave = reg_wr_in && (reg_addr_in == `VSP_OFF_SLAVE_CFG);
	assign wr_div = reg_wr_in && (reg_addr_in == `VSP_OFF_DIV_CTRL);
	assign wr_prot = reg_wr_in && (reg_addr_in == `VSP_OFF_PROT_CFG);
	assign wr_otl = reg_wr_in && (reg_addr_in == `VSP_OFF_OT_LIMIT);

	// Operation picks nominal, margin low or margin high as the source.
	assign margin_sel = operation_r[`VSP_OP_MARGIN_MSB:`VSP_OP_MARGIN_LSB];
	assign cmd_act_nxt = (margin_sel == 2'b01) ? margin_lo_r :
		(margin_sel == 2'b10) ? margin_hi_r : vout_set_r;

	// The power-good and control pins come from the analog domain: two flops each.
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			pg_pin_s1_r <= 1'b0;
			pg_pin_s2_r <= 1'b0;
			ctrl_s1_r <= 1'b0;
			ctrl_s2_r <= 1'b0;
			ctrl_prev_r <= 1'b0;
		end else begin
			pg_pin_s1_r <= power_good_pin_in;
			pg_pin_s2_r <= pg_pin_s1_r;
			ctrl_s1_r <= ctrl_enable_in;
			ctrl_s2_r <= ctrl_s1_r;
			ctrl_prev_r <= ctrl_s2_r;
		end
	end

	assign ctrl_rise = ctrl_s2_r && !ctrl_prev_r;
	assign run_req = ctrl_s2_r && operation_r[`VSP_OP_ON_BIT];
	// Equal to the limit is still safe; only a reading above it trips.
	assign ot_trip = junction_temp_in > ot_limit_r; // see (RQ1)
	// Pin low while we release it means something else pulls it down.
	// Our own pull-down takes two sync stages to leave the pin reading,
	// so the check waits until the settle flag is through.
	assign slave_fault = slave_cfg_r[`VSP_SLAVE_EN_BIT] && pg_released_r &&
		pg_settle_r[1] && !pg_pin_s2_r; // see (RQ17) see (RQ18)
	assign any_fault = ot_trip || under_voltage_in || over_voltage_in ||
		input_uvlo_in || slave_fault;

	// Settle flag: set two edges after the pin is released, cleared at once.
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			pg_settle_r <= 2'b00;
		end else begin
			pg_settle_r <= pg_released_r ? {pg_settle_r[0], 1'b1} : 2'b00;
		end
	end

	// Setpoint registers.
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			operation_r <= `VSP_RST_OPERATION;
			vout_set_r <= `VSP_RST_VOUT_SET;
			margin_hi_r <= `VSP_RST_MARGIN;
			margin_lo_r <= `VSP_RST_MARGIN;
			scale_r <= `VSP_RST_SCALE;
			slave_cfg_r <= `VSP_RST_SLAVE_CFG;
			div_ctrl_r <= `VSP_RST_DIV_CTRL;
			prot_cfg_r <= `VSP_RST_PROT_CFG;
			ot_limit_r <= `VSP_RST_OT_LIMIT;
		end else begin
			if (wr_op)
				operation_r <= reg_wdata_in[7:0];
			if (wr_vout)
				vout_set_r <= reg_wdata_in;
			if (wr_mhi)
				margin_hi_r <= reg_wdata_in;
			if (wr_mlo)
				margin_lo_r <= reg_wdata_in;
			if (wr_scale)
				scale_r <= reg_wdata_in;
			if (wr_slave)
				slave_cfg_r <= reg_wdata_in;
			if (wr_div)
				div_ctrl_r <= reg_wdata_in;
			if (wr_prot)
				prot_cfg_r <= reg_wdata_in;
			if (wr_otl)
				ot_limit_r <= reg_wdata_in;
		end
	end

	// Scale and divider are staged; only a voltage command write commits.
	// Margin sources follow the operation selection at once.
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			scale_act_r <= `VSP_RST_SCALE;
			div_act_r <= 2'b00;
			cmd_act_r <= `VSP_RST_VOUT_SET;
		end else begin
			if (wr_vout) begin
				scale_act_r <= scale_r; // see (RQ8)
				div_act_r <= div_ctrl_r[1:0]; // see (RQ8) see (RQ5)
			end
			cmd_act_r <= wr_vout && (margin_sel == 2'b00) ?
				reg_wdata_in : cmd_act_nxt;
		end
	end

	vsp_dac_calc u_dac_calc (
		.cmd_in(cmd_act_r),
		.scale_in(scale_act_r),
		.div_sel_in(div_act_r),
		.dac_mv_out(dac_mv)
	);

	// Readback: sensed output in 2 mV counts, same scale as the commands.
	// The sense word is not filtered; a read shows the latest sample.
	assign readback = vout_sense_in; // see (RQ13)

	// Power-good delay is steps of a fixed unit, chosen by bits 5:2.
	// The counter is wide enough for the longest code and the hiccup time.
	assign pg_steps = div_ctrl_r[5:2];
	assign pg_delay_cyc = 24'(`VSP_PG_STEP_CYC) * 24'(pg_steps); // see (RQ15)

	// Supervision sequence.
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		unique case (state_r)
			VSP_OFF: begin
				// Input undervoltage keeps the stage off whatever is asked.
				cnt_nxt = 24'h0;
				if (run_req && !input_uvlo_in)
					state_nxt = VSP_SOFT_START;
			end
			VSP_SOFT_START: begin
				cnt_nxt = 24'h0;
				if (!run_req)
					state_nxt = VSP_OFF;
				else if (ot_trip)
					state_nxt = prot_cfg_r[`VSP_PROT_LATCH_BIT] ?
						VSP_LATCHED : VSP_HICCUP; // see (RQ2)
				else if (any_fault)
					state_nxt = VSP_HICCUP;
				else if (soft_start_done_in && feedback_pg_on_in)
					state_nxt = VSP_PG_DELAY; // see (RQ14)
			end
			VSP_PG_DELAY: begin
				// Counts from entry; code zero releases on the next edge.
				cnt_nxt = cnt_r + 24'h1;
				if (!run_req)
					state_nxt = VSP_OFF;
				else if (ot_trip)
					state_nxt = prot_cfg_r[`VSP_PROT_LATCH_BIT] ?
						VSP_LATCHED : VSP_HICCUP; // see (RQ2)
				else if (any_fault)
					state_nxt = VSP_HICCUP;
				else if (cnt_r >= pg_delay_cyc)
					state_nxt = VSP_RUNNING; // see (RQ15)
			end
			VSP_RUNNING: begin
				cnt_nxt = 24'h0;
				if (!run_req)
					state_nxt = VSP_OFF;
				else if (ot_trip)
					state_nxt = prot_cfg_r[`VSP_PROT_LATCH_BIT] ?
						VSP_LATCHED : VSP_HICCUP; // see (RQ1) see (RQ2)
				else if (any_fault)
					state_nxt = VSP_HICCUP; // see (RQ16)
			end
			VSP_HICCUP: begin
				// Off time runs out, then off restarts through soft start.
				cnt_nxt = cnt_r + 24'h1;
				if (cnt_r >= 24'(`VSP_HICCUP_CYC - 32'd1))
					state_nxt = VSP_OFF;
			end
			VSP_LATCHED: begin
				cnt_nxt = 24'h0;
				// Only a control pin toggle or power cycle leaves here.
				if (ctrl_rise)
					state_nxt = VSP_OFF; // see (RQ3)
			end
			// Unused state codes fall back to off.
			default: begin
				cnt_nxt = 24'h0;
				state_nxt = VSP_OFF;
			end
		endcase
	end

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			state_r <= VSP_OFF;
			cnt_r <= 24'h0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// Register read mux.
	// Unmapped offsets read as zero and have no other effect.
	always_comb begin
		unique case (reg_addr_in)
			`VSP_OFF_OPERATION: rdata_nxt = {8'h00, operation_r};
			`VSP_OFF_VOUT_SET: rdata_nxt = vout_set_r;
			`VSP_OFF_MARGIN_HI: rdata_nxt = margin_hi_r;
			`VSP_OFF_MARGIN_LO: rdata_nxt = margin_lo_r;
			`VSP_OFF_SCALE: rdata_nxt = scale_r;
			`VSP_OFF_READBACK: rdata_nxt = readback; // see (RQ13)
			`VSP_OFF_SLAVE_CFG: rdata_nxt = slave_cfg_r;
			`VSP_OFF_DIV_CTRL: rdata_nxt = div_ctrl_r;
			`VSP_OFF_PROT_CFG: rdata_nxt = prot_cfg_r;
			`VSP_OFF_OT_LIMIT: rdata_nxt = ot_limit_r;
			default: rdata_nxt = 16'h0000;
		endcase
	end

	// Outputs, each from a flop. Power good stays driven low outside
	// the running state, so a fault holds it low until a new soft start.
	// The data bit is tied low; the enable alone moves the pin.
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			reg_rdata_out <= 16'h0000;
			reg_rvalid_out <= 1'b0;
			power_good_output_out <= 1'b0;
			power_good_oe_out <= 1'b1;
			pg_released_r <= 1'b0;
			converter_enable_out <= 1'b0;
			dac_target_out <= `VSP_DAC_MIN_MV;
			fault_latched_out <= 1'b0;
		end else begin
			reg_rdata_out <= reg_rd_in ? rdata_nxt : reg_rdata_out;
			reg_rvalid_out <= reg_rd_in;
			power_good_output_out <= 1'b0;
			power_good_oe_out <= (state_nxt != VSP_RUNNING); // see (RQ14) see (RQ16)
			pg_released_r <= (state_nxt == VSP_RUNNING);
			converter_enable_out <= (state_nxt == VSP_SOFT_START) ||
				(state_nxt == VSP_PG_DELAY) ||
				(state_nxt == VSP_RUNNING); // see (RQ1)
			dac_target_out <= dac_mv; // see (RQ4)
			fault_latched_out <= (state_nxt == VSP_LATCHED); // see (RQ3)
		end
	end
endmodule : vsp_setpoint_ctrl
`default_nettype wire

//--- tb/vsp_host_model.sv
// Register-bus host model that configures the setpoint block.
`timescale 1ns/1ps
`default_nettype none
module vsp_host_model (
	// Clock and read data.
	input wire logic clock_in,
	input wire logic [15:0] rdata_in,
	// Register strobes.
	output logic wr_out,
	output logic rd_out,
	output logic [7:0] addr_out,
	output logic [15:0] wdata_out
);
	initial begin
		wr_out = 1'b0;
		rd_out = 1'b0;
		addr_out = 8'h00;
		wdata_out = 16'h0000;
	end
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clock_in);
		#1 wr_out = 1'b1;
		addr_out = a;
		wdata_out = d;
		@(posedge clock_in);
		#1 wr_out = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clock_in);
		#1 rd_out = 1'b1;
		addr_out = a;
		@(posedge clock_in);
		#1 rd_out = 1'b0;
		d = rdata_in;
	endtask : rd
	// Only called while the stage is idle; the voltage command goes last.
	task automatic setup(input logic [15:0] ctl, sc, cmd);
		wr(8'h01, 16'h0080);
		wr(8'hd1, ctl);
		wr(8'h29, sc);
		wr(8'h21, cmd);
	endtask : setup
endmodule : vsp_host_model
`default_nettype wire

//--- tb/vsp_ctrl_monitor.sv
// Concurrent checks on the ports of the setpoint block.
`timescale 1ns/1ps
`default_nettype none
module vsp_ctrl_monitor (
	// Clock, reset and bus.
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic reg_rd_in,
	input wire logic reg_rvalid_out,
	// Supervision.
	input wire logic ctrl_enable_in,
	input wire logic feedback_pg_on_in,
	input wire logic under_voltage_in,
	input wire logic over_voltage_in,
	input wire logic input_uvlo_in,
	input wire logic power_good_output_out,
	input wire logic power_good_oe_out,
	input wire logic converter_enable_out,
	input wire logic [15:0] dac_target_out,
	input wire logic fault_latched_out
);
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);
	rd_answer_a: assert property (reg_rd_in |=> reg_rvalid_out)
		else $error("read not answered");
	no_stray_valid_a: assert property (!reg_rd_in |=> !reg_rvalid_out)
		else $error("stray read valid");
	dac_span_a: assert property (dac_target_out >= 16'd162 &&
		dac_target_out <= 16'd672) else $error("reference out of span");
	pg_open_drain_a: assert property (power_good_output_out == 1'b0)
		else $error("pin driven high");
	off_pg_low_a: assert property (!converter_enable_out |-> power_good_oe_out)
		else $error("pin released while off");
	latch_stops_a: assert property (fault_latched_out |-> !converter_enable_out)
		else $error("running while latched");
	fault_pg_a: assert property ((converter_enable_out && (under_voltage_in ||
		over_voltage_in || input_uvlo_in)) |-> ##[1:2]
		(power_good_oe_out && !converter_enable_out)) else $error("fault missed");
	latch_hold_a: assert property ((fault_latched_out && !ctrl_enable_in &&
		!$past(ctrl_enable_in) && !$past(ctrl_enable_in, 2)) |=>
		fault_latched_out) else $error("latch left without toggle");
	pg_release_a: assert property ($fell(power_good_oe_out) |->
		converter_enable_out && feedback_pg_on_in) else $error("early release");
	cover property ($fell(power_good_oe_out));
	cover property ($rose(fault_latched_out));
	cover property ($fell(converter_enable_out) && !fault_latched_out);
endmodule : vsp_ctrl_monitor
bind vsp_setpoint_ctrl vsp_ctrl_monitor vsp_ctrl_monitor_i (
	.clock_in(clock_in), .rst_n_in(rst_n_in), .reg_rd_in(reg_rd_in),
	.reg_rvalid_out(reg_rvalid_out), .ctrl_enable_in(ctrl_enable_in),
	.feedback_pg_on_in(feedback_pg_on_in), .under_voltage_in(under_voltage_in),
	.over_voltage_in(over_voltage_in), .input_uvlo_in(input_uvlo_in),
	.power_good_output_out(power_good_output_out),
	.power_good_oe_out(power_good_oe_out),
	.converter_enable_out(converter_enable_out),
	.dac_target_out(dac_target_out), .fault_latched_out(fault_latched_out));
`default_nettype wire

//--- tb/vsp_setpoint_ctrl_tb_top.sv
// Self-checking bench for the setpoint and supervision block.
`timescale 1ns/1ps
`default_nettype none
module vsp_setpoint_ctrl_tb_top;
	logic clock_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic ctl = 1'b0, ss = 1'b0, pgon = 1'b0, pull_low = 1'b0;
	logic [2:0] flt = 3'h0;
	logic [15:0] temp = 16'h0000, vs = 16'h0000;
	logic wr, rd, rv, pgd, oe, en, lat;
	logic [7:0] ad;
	logic [15:0] wd, rdat, dac, got;
	wire logic pg_pin;
	int n_mismatch = 0;
	int check_count = 0;
	int cyc = 0;
	// Pull-up on the pin; a faulty slave may hold it low.
	assign pg_pin = oe ? pgd : !pull_low;
	vsp_setpoint_ctrl vsp_setpoint_ctrl_i (.clock_in(clock_in),
		.rst_n_in(rst_n_in), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_addr_in(ad), .reg_wdata_in(wd), .reg_rdata_out(rdat),
		.reg_rvalid_out(rv), .ctrl_enable_in(ctl), .junction_temp_in(temp),
		.vout_sense_in(vs), .feedback_pg_on_in(pgon),
		.soft_start_done_in(ss), .under_voltage_in(flt[0]),
		.over_voltage_in(flt[1]), .input_uvlo_in(flt[2]),
		.power_good_pin_in(pg_pin), .power_good_output_out(pgd),
		.power_good_oe_out(oe), .converter_enable_out(en),
		.dac_target_out(dac), .fault_latched_out(lat));
	vsp_host_model vsp_host_model_i (.clock_in(clock_in), .rdata_in(rdat),
		.wr_out(wr), .rd_out(rd), .addr_out(ad), .wdata_out(wd));
	initial begin
		forever #50 clock_in = !clock_in;
	end
	always @(posedge clock_in) begin
		cyc++;
		if (cyc == 8000) begin
			n_mismatch++;
			$display("wrong value at %0t: timeout", $time);
			close_out();
		end
	end
	task automatic close_out;
		if (n_mismatch == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : close_out
	task automatic chk(input logic [15:0] g, e);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic chk1(input logic g, e);
		chk({15'h0, g}, {15'h0, e});
	endtask : chk1
	task automatic tick(input int n);
		repeat (n) @(posedge clock_in);
		#1;
	endtask : tick
	task automatic w(input logic [7:0] a, input logic [15:0] d);
		vsp_host_model_i.wr(a, d);
	endtask : w
	task automatic r(input logic [7:0] a, input logic [15:0] e);
		vsp_host_model_i.rd(a, got);
		chk(got, e);
		chk1(rv, 1'b1);
	endtask : r
	task automatic rst;
		@(posedge clock_in);
		#1 rst_n_in = 1'b0;
		{ctl, ss, pgon, pull_low, flt, temp} = '0;
		tick(4);
		chk1(oe, 1'b1);
		chk1(en, 1'b0);
		rst_n_in = 1'b1;
	endtask : rst
	task automatic run_up(input int n);
		ctl = 1'b1;
		ss = 1'b1;
		pgon = 1'b1;
		for (int i = 0; i < n && oe !== 1'b0; i++) begin
			tick(1);
		end
	endtask : run_up
	task automatic t_regs;
		r(8'h29, 16'h03e8);
		r(8'hd1, 16'h0000);
		r(8'hd0, 16'h0001);
		r(8'h40, 16'h0000);
		vs = 16'h04e2;
		w(8'h8b, 16'h1234);
		r(8'h8b, 16'h04e2);
	endtask : t_regs
	task automatic t_div;
		int e;
		for (int k = 0; k < 4; k++) begin
			vsp_host_model_i.setup(16'(k), 16'(1000 >> k), 16'h04e2);
			tick(4);
			e = (2500 * (1000 >> k)) / 1000;
			chk(dac, 16'((e > 672) ? 672 : e));
		end
		w(8'hd1, 16'h0000);
		w(8'h29, 16'h03e8);
		tick(4);
		chk(dac, 16'd312);
		w(8'h21, 16'h0010);
		tick(4);
		chk(dac, 16'd162);
		w(8'h21, 16'h012c);
		tick(4);
		chk(dac, 16'd600);
	endtask : t_div
	task automatic t_pg;
		rst();
		w(8'hd1, 16'h0004);
		run_up(20);
		chk1(en, 1'b1);
		tick(900);
		chk1(oe, 1'b1);
		run_up(300);
		chk1(oe, 1'b0);
		chk1(pgd, 1'b0);
		pull_low = 1'b1;
		tick(6);
		chk1(en, 1'b0);
		chk1(oe, 1'b1);
		rst();
		w(8'hd0, 16'h0000);
		run_up(60);
		pull_low = 1'b1;
		tick(6);
		chk1(en, 1'b1);
	endtask : t_pg
	task automatic t_flt;
		for (int k = 0; k < 5; k++) begin
			rst();
			w(8'hd2, {15'h0, k == 4});
			run_up(60);
			if (k < 3) begin
				flt = 3'(1 << k);
			end else begin
				temp = 16'h00a0;
				tick(5);
				chk1(en, 1'b1);
				temp = 16'h00a1;
			end
			tick(3);
			chk1(en, 1'b0);
			chk1(lat, k == 4);
			{flt, temp} = '0;
			tick(20);
			chk1(oe, 1'b1);
		end
		w(8'hd2, 16'h0000);
		w(8'h21, 16'h01c2);
		chk1(lat, 1'b1);
		ctl = 1'b0;
		tick(5);
		ctl = 1'b1;
		tick(8);
		chk1(lat, 1'b0);
		chk1(en, 1'b1);
	endtask : t_flt
	initial begin
		rst();
		t_regs();
		t_div();
		t_pg();
		t_flt();
		close_out();
	end
endmodule : vsp_setpoint_ctrl_tb_top
`default_nettype wire
